// ---- logic/modem_status_map.svh ----
/*
  Register map, field positions and reset values of the
  handshake input status block.
  Assumes a 32-bit AXI4-Lite slave in which each register takes one aligned word.
*/
// Overview of operation
// - Status register is read-only; writes change nothing
// - Bit 0 flags CTS change, cleared after read
// - Bit 1 flags DSR change, cleared on read
// - Bit 2 flags RI rising edge only
// - Bit 3 flags DCD change, cleared on read
// - Bit 4 shows inverted CTS, loopback control bit 1
// - Bit 5 shows inverted DSR, loopback control bit 0
// - Bit 6 shows inverted RI, loopback control bit 2
`ifndef MODEM_STATUS_MAP_SVH
`define MODEM_STATUS_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define MSD_OFS_STATUS 12'h000
`define MSD_OFS_CONTROL 12'h004
`define MSD_OFS_EVENT 12'h008
`define MSD_OFS_MASK 12'h00c

// ==========================================================================
// Line index inside every four-bit vector
`define MSD_LINE_CTS 0
`define MSD_LINE_DSR 1
`define MSD_LINE_RI 2
`define MSD_LINE_DCD 3

// ==========================================================================
// Status register fields
`define MSD_STATUS_DELTA_LSB 0
`define MSD_STATUS_STATE_LSB 4

// ==========================================================================
// Control register fields
`define MSD_CTRL_DSR_BIT 0
`define MSD_CTRL_CTS_BIT 1
`define MSD_CTRL_RI_BIT 2
`define MSD_CTRL_DCD_BIT 3
`define MSD_CTRL_LOOP_BIT 4

// ==========================================================================
// Reset values
`define MSD_RST_DELTA 4'h0
`define MSD_RST_CONTROL 5'h00
`define MSD_RST_EVENT 4'h0
`define MSD_RST_MASK 4'h0
`define MSD_RST_PIN 4'hf

`endif

// ---- logic/modem_status_pkg.sv ----
/*
  Types shared by the handshake input status block.
  Assumes the map header supplies the register constants; the bus response codes are set here.
*/
package modem_status_pkg;

  // ========================================================================
  // Types
  typedef logic [3:0] line_vec_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage : modem_status_pkg

// ---- logic/handshake_link_if.sv ----
/*
  Carrier between the status top and its line sensing module.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface handshake_link_if;
  logic loopback;
  modem_status_pkg::line_vec_t loop_state;
  modem_status_pkg::line_vec_t level;
  modem_status_pkg::line_vec_t change;
  modem_status_pkg::line_vec_t rise;

  modport sense (input loopback, input loop_state, output level, output change, output rise);
  modport user (output loopback, output loop_state, input level, input change, input rise);
endinterface : handshake_link_if

// ---- logic/handshake_line_sense.sv ----
/*
  Synchronises the four handshake pins, applies loopback and finds edges.
  Assumes pins are asynchronous and loopback control comes from the same clock.
*/
`timescale 1ns/1ps
`include "modem_status_map.svh"
module handshake_line_sense (
  input wire logic aclk,
  input wire logic aresetn,
  input wire modem_status_pkg::line_vec_t pin,
  handshake_link_if.sense link
);
  modem_status_pkg::line_vec_t sync_a;
  modem_status_pkg::line_vec_t sync_b;
  modem_status_pkg::line_vec_t prev;
  modem_status_pkg::line_vec_t next_sync_a;
  modem_status_pkg::line_vec_t next_sync_b;
  modem_status_pkg::line_vec_t next_prev;
  modem_status_pkg::line_vec_t cur;

  // ========================================================================
  // Next values: two-stage sync, then loopback select at pin polarity
  always_comb begin
    next_sync_a = pin;
    next_sync_b = sync_a;
    // Loopback state bits are asserted-high, so invert to pin polarity
    cur = link.loopback ? ~link.loop_state : sync_b;
    next_prev = cur;
  end

  // Edges compare against last sampled level; only sync_b feeds logic
  assign link.level = cur;
  assign link.change = cur ^ prev;
  assign link.rise = cur & ~prev;

  // ========================================================================
  // Registers; pins idle high so reset to high avoids false edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= `MSD_RST_PIN;
      sync_b <= `MSD_RST_PIN;
      prev <= `MSD_RST_PIN;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
    end
  end
endmodule : handshake_line_sense

// ---- logic/uart_modem_status_deltas.sv ----
/*
  Handshake input status block of a serial port with an AXI4-Lite slave,
  change flags, loopback control and a masked interrupt.
  Assumes one clock, synchronous active-low reset and asynchronous pins.
*/
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "modem_status_map.svh"
module uart_modem_status_deltas #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);
  // ========================================================================
  // Declarations
  handshake_link_if link ();
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic next_aw_held, next_w_held;
  logic [ADDR_W-1:0] next_waddr;
  logic [31:0] next_wdat, next_rdata;
  logic [3:0] next_wstb;
  logic [1:0] next_bresp, next_rresp;
  logic wr_fire, rd_fire;
  logic [11:0] wr_ofs, rd_ofs;
  modem_status_pkg::line_vec_t delta, next_delta;
  modem_status_pkg::line_vec_t event_st, next_event_st;
  modem_status_pkg::line_vec_t mask, next_mask;
  modem_status_pkg::line_vec_t ev;
  modem_status_pkg::line_vec_t state;
  logic [4:0] control, next_control;
  logic next_irq;

  // ========================================================================
  // Line sensing
  handshake_line_sense sense (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({dcd_n, ri_n, dsr_n, cts_n}),
    .link(link)
  );

  // Loopback sources, each line from its own control bit
  assign link.loopback = control[`MSD_CTRL_LOOP_BIT];
  assign link.loop_state[`MSD_LINE_CTS] = control[`MSD_CTRL_CTS_BIT];
  assign link.loop_state[`MSD_LINE_DSR] = control[`MSD_CTRL_DSR_BIT];
  assign link.loop_state[`MSD_LINE_RI] = control[`MSD_CTRL_RI_BIT];
  assign link.loop_state[`MSD_LINE_DCD] = control[`MSD_CTRL_DCD_BIT];

  // Live state is the complement of the pin (or the loopback bit itself)
  assign state = ~link.level;

  // Flag events: any change on CTS, DSR, DCD; rising pin only on RI
  assign ev[`MSD_LINE_CTS] = link.change[`MSD_LINE_CTS];
  assign ev[`MSD_LINE_DSR] = link.change[`MSD_LINE_DSR];
  assign ev[`MSD_LINE_RI] = link.rise[`MSD_LINE_RI];
  assign ev[`MSD_LINE_DCD] = link.change[`MSD_LINE_DCD];

  // ========================================================================
  // Bus handshakes
  assign wr_fire = aw_held & w_held & ~bvalid;
  assign rd_fire = arvalid & arready;
  // Word-aligned byte offset; the cast keeps it at the 12 bits of the map
  assign wr_ofs = 12'({waddr[ADDR_W-1:2], 2'b00});
  assign rd_ofs = 12'({araddr[ADDR_W-1:2], 2'b00});

  // Address and data are taken in either order and held until both are in
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wdat = wdat;
    next_wstb = wstb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_arready = arready;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_waddr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wdat = wdata;
      next_wstb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (wr_ofs)
        `MSD_OFS_STATUS, `MSD_OFS_CONTROL, `MSD_OFS_EVENT, `MSD_OFS_MASK: begin
          next_bresp = modem_status_pkg::RESP_OKAY;
        end
        default: begin
          next_bresp = modem_status_pkg::RESP_SLVERR;
        end
      endcase
    end
    // One read at a time: arready drops until the data is taken
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (rd_fire) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = modem_status_pkg::RESP_OKAY;
      unique case (rd_ofs)
        `MSD_OFS_STATUS: next_rdata = {24'h00_0000, state, delta};
        `MSD_OFS_CONTROL: next_rdata = {27'h000_0000, control};
        `MSD_OFS_EVENT: next_rdata = {28'h000_0000, event_st};
        `MSD_OFS_MASK: next_rdata = {28'h000_0000, mask};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = modem_status_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Ready falls while a channel is held or a response is pending
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= '0;
      wdat <= 32'h0000_0000;
      wstb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdat <= next_wdat;
      wstb <= next_wstb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      // Readies rise at the first edge after reset release
      arready <= next_arready | (~arready & ~rvalid);
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ========================================================================
  // Flags, control, interrupt
  // Reading the status word clears its flags, but a new edge in the same
  // cycle wins so the event shows on the next read instead of being lost.
  always_comb begin
    next_delta = delta;
    next_event_st = event_st;
    next_control = control;
    next_mask = mask;
    if (rd_fire && (rd_ofs == `MSD_OFS_STATUS)) begin
      next_delta = `MSD_RST_DELTA;
    end
    // Only byte lane 0 holds writable bits; status writes are dropped
    if (wr_fire && wstb[0]) begin
      unique case (wr_ofs)
        `MSD_OFS_CONTROL: next_control = wdat[4:0];
        `MSD_OFS_EVENT: next_event_st = event_st & ~wdat[3:0];
        `MSD_OFS_MASK: next_mask = wdat[3:0];
        default: next_control = control;
      endcase
    end
    next_delta = next_delta | ev;
    next_event_st = next_event_st | ev;
    next_irq = |(next_event_st & next_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delta <= `MSD_RST_DELTA;
      event_st <= `MSD_RST_EVENT;
      control <= `MSD_RST_CONTROL;
      mask <= `MSD_RST_MASK;
      irq <= 1'b0;
    end else begin
      delta <= next_delta;
      event_st <= next_event_st;
      control <= next_control;
      mask <= next_mask;
      irq <= next_irq;
    end
  end
endmodule : uart_modem_status_deltas

// ---- bench/modem_line_model.sv ----
/*
  Stand-in for the attached modem: drives the four handshake pins.
  Assumes the bench asks for new levels in the aclk domain.
*/
`timescale 1ns/1ps
module modem_line_model (
  input wire logic aclk,
  input wire modem_status_pkg::line_vec_t want,
  output modem_status_pkg::line_vec_t pin
);
  // ==========================================
  // Pins idle high, then follow one edge late, as a slow driver would
  initial pin = 4'hf;
  always @(posedge aclk) begin
    pin <= want;
  end
endmodule : modem_line_model

// ---- bench/uart_modem_status_deltas_asserts.sv ----
/*
  Bus timing checker for the status block.
  Assumes it is bound to the block top and sees only its ports.
*/
`timescale 1ns/1ps
module uart_modem_status_deltas_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Write and read steps
  sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence wr_closed; bvalid && bready; endsequence
  sequence rd_taken; arvalid && arready; endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 bvalid) else $error("write answer late");
  chk_write_blocks: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
  chk_write_done: assert property (wr_closed |=> !bvalid ##1 (awready && wready)) else $error("write not reopened");
  chk_read_answer: assert property (rd_taken |=> rvalid) else $error("read answer late");
  chk_read_blocks: assert property (rvalid |-> !arready) else $error("read taken while busy");
  chk_read_done: assert property (rvalid && rready |=> !rvalid && arready) else $error("read not reopened");
  chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  // Reset must silence every answer, so this one ignores the default disable
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !irq)
    else $error("answer during reset");
endmodule : uart_modem_status_deltas_asserts
bind uart_modem_status_deltas uart_modem_status_deltas_asserts #(.ADDR_W(ADDR_W)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .irq(irq));

// ---- bench/uart_modem_status_deltas_test.sv ----
/*
  Self-checking bench for the handshake input status block.
  Assumes the map header and package are compiled first.
*/
`timescale 1ns/1ps
`include "modem_status_map.svh"
module uart_modem_status_deltas_test;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d, e;
  logic [3:0] lanes = 4'hf;
  logic [3:0] wstrb = '0, old, nw, c;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  modem_status_pkg::line_vec_t want = 4'hf, pin;
  int mismatches = 0, total_checks = 0;
  always #2 aclk = ~aclk;
  // ==========================================
  // Far side and block
  modem_line_model i_modem_line_model (.aclk(aclk), .want(want), .pin(pin));
  uart_modem_status_deltas #(.ADDR_W(12)) i_uart_modem_status_deltas (
    .aclk(aclk), .aresetn(aresetn), .cts_n(pin[0]), .dsr_n(pin[1]), .ri_n(pin[2]), .dcd_n(pin[3]),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
  // ==========================================
  // Verdict, comparison and bus tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Each channel drops its valid at the edge that takes it
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= lanes;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        resp = bresp;
        bready <= 1'h0;
        return;
      end
    end
    mismatches++;
    report_and_stop();
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        v = rdata;
        resp = rresp;
        rready <= 1'h0;
        return;
      end
    end
    mismatches++;
    report_and_stop();
  endtask : axi_read
  // Status word for pins {dcd,ri,dsr,cts}; the ring flag wants the pin to rise
  function automatic logic [31:0] exp_status(input logic [3:0] o, input logic [3:0] n);
    logic [3:0] delta;
    delta = o ^ n;
    delta[2] = !o[2] && n[2];
    return {24'h00_0000, ~n, delta};
  endfunction : exp_status
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(18));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      axi_read(12'(4 * i), d, r);
      check(d, 32'h0000_0000);
    end
    // Status ignores writes; an unmapped place is refused
    axi_write(`MSD_OFS_STATUS, 32'hffff_ffff, r);
    check(32'(r), 32'h0000_0000);
    axi_read(`MSD_OFS_STATUS, d, r);
    check(d, 32'h0000_0000);
    axi_write(12'h010, 32'h0000_000f, r);
    check(32'(r), 32'h0000_0002);
    axi_read(12'h010, d, r);
    check({d[29:0], r}, 32'h0000_0002);
    // A write without byte lane 0 answers OKAY but changes nothing
    lanes = 4'he;
    axi_write(`MSD_OFS_CONTROL, 32'h0000_001f, r);
    lanes = 4'hf;
    check(32'(r), 32'h0000_0000);
    axi_read(`MSD_OFS_CONTROL, d, r);
    check(d, 32'h0000_0000);
    axi_write(`MSD_OFS_MASK, 32'h0000_000f, r);
    // Single-line toggles first (ring falls at step 2, rises at step 4), then random pin sets
    old = 4'hf;
    for (int i = 0; i < 24; i++) begin
      nw = (i < 4) ? old ^ (4'h1 << i) : (i == 4) ? old ^ 4'h4 : 4'($urandom());
      e = exp_status(old, nw);
      want <= nw;
      repeat (6) @(posedge aclk);
      check(32'(irq), 32'(|e[3:0]));
      axi_read(`MSD_OFS_EVENT, d, r);
      check(d, 32'(e[3:0]));
      axi_read(`MSD_OFS_STATUS, d, r);
      check(d, e);
      axi_read(`MSD_OFS_STATUS, d, r);
      check(d, exp_status(nw, nw));
      axi_write(`MSD_OFS_EVENT, 32'h0000_000f, r);
      repeat (2) @(posedge aclk);
      check(32'(irq), 32'h0000_0000);
      old = nw;
    end
    // Masked events leave the interrupt low
    axi_write(`MSD_OFS_MASK, 32'h0000_0000, r);
    want <= old ^ 4'h1;
    repeat (6) @(posedge aclk);
    check(32'(irq), 32'h0000_0000);
    // Loopback: state bits follow the control word instead of the pins
    for (int j = 0; j < 6; j++) begin
      c = (j < 4) ? 4'h1 << j : 4'($urandom());
      axi_write(`MSD_OFS_CONTROL, {27'h000_0000, 1'h1, c}, r);
      repeat (6) @(posedge aclk);
      axi_read(`MSD_OFS_STATUS, d, r);
      check(32'(d[7:4]), 32'({c[3], c[2], c[0], c[1]}));
    end
    report_and_stop();
  end
endmodule : uart_modem_status_deltas_test
